// ---- hdl/adbw_pkg.sv ----
/*
 * Package for the area decoder and bus width selector: address fields,
 * width codes, area numbers and the carrier structs.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package adbw_pkg;

    // ------------------------------------------------------------------
    // Address fields
    // ------------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int AREA_MSB = 28;
    localparam int AREA_LSB = 26;
    localparam int AREA_W = 3;
    localparam int UPPER_MSB = 31;
    localparam int UPPER_LSB = 29;
    localparam int NUM_AREAS = 8;
    localparam int NUM_SELECTS = 7;

    localparam logic [2:0] AREA_0 = 3'h0;
    localparam logic [2:0] AREA_1 = 3'h1;
    localparam logic [2:0] AREA_2 = 3'h2;
    localparam logic [2:0] AREA_3 = 3'h3;
    localparam logic [2:0] AREA_5 = 3'h5;
    localparam logic [2:0] AREA_6 = 3'h6;
    localparam logic [2:0] AREA_7 = 3'h7;

    // Logical region that bypasses translation: top three bits
    localparam logic [2:0] UNTRANSLATED_TOP = 3'h5;

    // ------------------------------------------------------------------
    // Width codes (strap and per-area setting share the encoding)
    // ------------------------------------------------------------------
    localparam logic [1:0] WIDTH_RSVD = 2'h0;
    localparam logic [1:0] WIDTH_8 = 2'h1;
    localparam logic [1:0] WIDTH_16 = 2'h2;
    localparam logic [1:0] WIDTH_32 = 2'h3;
    localparam logic [1:0] WIDTH_RESET = WIDTH_32;
    localparam int CFG_FIRST = 2;
    localparam int CFG_LAST = 6;
    localparam int CFG_W = 2 * NUM_AREAS;

    // Memory type per area
    localparam logic [1:0] MEM_ORDINARY = 2'h0;
    localparam logic [1:0] MEM_SDRAM = 2'h1;
    localparam logic [1:0] MEM_CARD = 2'h2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic translated;
        logic [3:0] byte_en;
        logic [ADDR_W-1:0] addr;
    } adbw_req_t;

    typedef struct packed {
        logic external;
        logic io_space;
        logic card;
        logic [AREA_W-1:0] area;
        logic [1:0] width;
    } adbw_dec_t;

    typedef enum logic [1:0] {
        ADBW_ORDER_BIG,
        ADBW_ORDER_LITTLE
    } adbw_order_t;

endpackage

// ---- hdl/adbw_area_decode.sv ----
/*
 * Combinational area decoder: picks the area from the physical address,
 * folds shadow copies and flags on-chip I/O space.
 * Assumes a physical address that is valid in the same cycle.
 */
`timescale 1ns/1ps
module adbw_area_decode (
    input wire logic [adbw_pkg::ADDR_W-1:0] addr_i,
    output logic [adbw_pkg::AREA_W-1:0] area_o,
    output logic external_o,
    output logic io_space_o
);
    import adbw_pkg::*;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Upper bits 31..29 are not looked at, so every copy folds
    always_comb begin
        area_o = addr_i[AREA_MSB:AREA_LSB];
        io_space_o = (area_o == AREA_7);
        external_o = (area_o != AREA_7) && (area_o != AREA_1);
    end

endmodule

// ---- hdl/adbw_top.sv ----
/*
 * Area decoder and per-area bus width selector of the external bus
 * controller. Takes an access request, decodes the area, drives one
 * chip select per external area and the card upper enables, and
 * reports the bus width to use.
 * Assumes straps stable during reset, configuration written by
 * software, and the master never touching reserved area 7.
 */
// Function
// - At reset latch area 0 width from straps: 01=8, 10=16, 11=32.
// - Areas 2 to 6 take width from the software width setting.
// - Address bits 28 to 26 select areas 0 to 6.
// - Address bits 31 to 29 are ignored, giving shadow copies.
// - Area 0 spans 0x0 to 0x03FFFFFF; each area next aligned base.
// - 0x1C000000 to 0x1FFFFFFF is area 7, on-chip I/O, not external.
// - Card interface exists only in areas 5 and 6.
// - Card I/O dynamic sizing only in little-endian mode.
// - Card areas reachable via translated and untranslated regions.
// - An area select is asserted only while that area is accessed; while clk_en_i is low the last select is held.
// - Card mode in areas 5 or 6 at 16-bit width also asserts that area's card upper enable (A for area 5, B for area 6) when byte 1 or 3 is enabled.
`timescale 1ns/1ps
module adbw_top (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic width_strap_high_i,
    input wire logic width_strap_low_i,
    input wire logic [adbw_pkg::CFG_W-1:0] area_width_config_i,
    input wire logic [adbw_pkg::CFG_W-1:0] area_mem_type_i,
    input wire logic little_endian_i,
    input wire logic card_io_space_i,
    input wire logic card_dyn_size_i,
    input wire logic card_iois16_n_i,
    input wire logic port_function_i,
    input wire adbw_pkg::adbw_req_t req_i,
    output logic [adbw_pkg::NUM_SELECTS-1:0] area_select_n_o,
    output logic card_a_upper_enable_n_o,
    output logic card_b_upper_enable_n_o,
    output adbw_pkg::adbw_dec_t dec_o,
    output logic [1:0] area0_width_o,
    output logic config_error_o,
    output logic io_access_o
);
    import adbw_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [1:0] field2(input logic [CFG_W-1:0] v,
                                          input logic [AREA_W-1:0] a);
        field2 = v[2*a +: 2];
    endfunction

    function automatic logic is_card_area(input logic [AREA_W-1:0] a);
        is_card_area = (a == AREA_5) || (a == AREA_6);
    endfunction

    // ------------------------------------------------------------------
    // Area 0 strap capture
    // ------------------------------------------------------------------
    logic strap_taken;
    logic [1:0] area0_width;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            strap_taken <= 1'b0;
            area0_width <= WIDTH_RESET;
        end else if (clk_en_i && !strap_taken) begin
            // Caught once after release, then held
            strap_taken <= 1'b1;
            area0_width <= {width_strap_high_i, width_strap_low_i};
        end
    end

    // ------------------------------------------------------------------
    // Area decode
    // ------------------------------------------------------------------
    logic [AREA_W-1:0] area;
    logic external;
    logic io_space;

    adbw_area_decode u_decode (
        .addr_i(req_i.addr),
        .area_o(area),
        .external_o(external),
        .io_space_o(io_space)
    );

    // ------------------------------------------------------------------
    // Width selection
    // ------------------------------------------------------------------
    logic [1:0] next_width;
    logic [1:0] mem_type;
    logic next_card;
    logic [1:0] next_upper_n;
    logic next_cfg_err;

    always_comb begin
        mem_type = field2(area_mem_type_i, area);
        if (area == AREA_0) begin
            next_width = area0_width;
        end else if (area >= AREA_2 && area <= AREA_6) begin
            next_width = field2(area_width_config_i, area);
        end else begin
            next_width = WIDTH_32;
        end
        // Card mode honoured only in areas 5 and 6
        // Either logical region reaches it: translation is ignored
        next_card = external && is_card_area(area) && (mem_type == MEM_CARD);
        // Dynamic sizing of card I/O needs little-endian order
        if (next_card && card_io_space_i && card_dyn_size_i
                && little_endian_i && card_iois16_n_i) begin
            next_width = WIDTH_8;
        end
        // Upper enables follow the high byte lane of a 16-bit card
        next_upper_n = 2'h3;
        if (req_i.valid && next_card && next_width == WIDTH_16
                && (req_i.byte_en[1] || req_i.byte_en[3])) begin
            if (area == AREA_5) begin
                next_upper_n = 2'h2;
            end else begin
                next_upper_n = 2'h1;
            end
        end
        // Flag settings software must avoid
        next_cfg_err = (area0_width == WIDTH_RSVD);
        if (mem_type == MEM_SDRAM && next_width == WIDTH_8) begin
            next_cfg_err = 1'b1;
        end
        if (next_card && next_width == WIDTH_32) begin
            next_cfg_err = 1'b1;
        end
        if (field2(area_mem_type_i, AREA_2) == MEM_SDRAM
                && field2(area_mem_type_i, AREA_3) == MEM_SDRAM
                && field2(area_width_config_i, AREA_2)
                   != field2(area_width_config_i, AREA_3)) begin
            next_cfg_err = 1'b1;
        end
        if (port_function_i && next_width == WIDTH_32) begin
            next_cfg_err = 1'b1;
        end
        if (req_i.valid && io_space) begin
            next_cfg_err = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            area_select_n_o <= '1;
        end else if (clk_en_i) begin
            area_select_n_o <= '1;
            // One select per external area, only during access
            if (req_i.valid && external) begin
                area_select_n_o[area] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            card_a_upper_enable_n_o <= 1'b1;
            card_b_upper_enable_n_o <= 1'b1;
        end else if (clk_en_i) begin
            card_a_upper_enable_n_o <= next_upper_n[0];
            card_b_upper_enable_n_o <= next_upper_n[1];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            dec_o <= '0;
            config_error_o <= 1'b0;
            io_access_o <= 1'b0;
        end else if (clk_en_i) begin
            dec_o.external <= req_i.valid && external;
            dec_o.io_space <= req_i.valid && io_space;
            dec_o.card <= req_i.valid && next_card;
            dec_o.area <= area;
            dec_o.width <= next_width;
            config_error_o <= next_cfg_err;
            io_access_o <= req_i.valid && io_space;
        end
    end

    assign area0_width_o = area0_width;

endmodule

// ---- test/adbw_mem_model.sv ----
/* External memory side: one device behind each area select.
   Assumes active-low selects, at most one low at a time. */
`timescale 1ns/1ps
module adbw_mem_model (
    input wire logic [adbw_pkg::NUM_SELECTS-1:0] select_n_i,
    output logic hit_o,
    output logic [2:0] hit_area_o
);
    import adbw_pkg::*;
    always_comb begin
        hit_o = 1'h0;
        hit_area_o = 3'h0;
        for (int i = 0; i < NUM_SELECTS; i++) begin
            if (!select_n_i[i]) begin
                hit_o = 1'h1;
                hit_area_o = 3'(i);
            end
        end
    end
endmodule

// ---- test/adbw_chk.sv ----
/* Checker for adbw_top: selects, area, straps and widths.
   Assumes one clock domain and a synchronous reset. */
`timescale 1ns/1ps
module adbw_chk (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic width_strap_high_i,
    input wire logic width_strap_low_i,
    input wire logic [adbw_pkg::CFG_W-1:0] area_width_config_i,
    input wire logic [adbw_pkg::CFG_W-1:0] area_mem_type_i,
    input wire logic little_endian_i,
    input wire logic card_io_space_i,
    input wire logic card_dyn_size_i,
    input wire logic card_iois16_n_i,
    input wire adbw_pkg::adbw_req_t req_i,
    input wire logic [adbw_pkg::NUM_SELECTS-1:0] area_select_n_o,
    input wire logic card_a_upper_enable_n_o,
    input wire adbw_pkg::adbw_dec_t dec_o,
    input wire logic [1:0] area0_width_o,
    input wire logic io_access_o
);
    import adbw_pkg::*;
    logic go;
    logic [2:0] ar;
    logic [1:0] cw;
    logic [1:0] mt;
    logic sizing;
    assign go = clk_en_i && req_i.valid;
    assign ar = req_i.addr[AREA_MSB:AREA_LSB];
    assign cw = area_width_config_i[2*ar+:2];
    assign mt = area_mem_type_i[2*ar+:2];
    assign sizing = card_io_space_i && card_dyn_size_i && little_endian_i
        && card_iois16_n_i;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sel_one_hot_a: assert property (go && ar != AREA_1
        && ar != AREA_7 |=> area_select_n_o == ~(7'h01 << $past(ar)))
        else $error("area select mismatch");
    sel_idle_a: assert property (clk_en_i && !req_i.valid
        |=> &area_select_n_o)
        else $error("select without request");
    io_space_a: assert property (go && ar == AREA_7
        |=> io_access_o && !dec_o.external && &area_select_n_o)
        else $error("area 7 treated as external");
    dec_area_a: assert property (go |=> dec_o.area == $past(ar))
        else $error("decoded area mismatch");
    strap_latch_a: assert property (!$past(rst_n_i)
        |=> area0_width_o == $past({width_strap_high_i, width_strap_low_i}))
        else $error("strap width not latched");
    strap_hold_a: assert property (
        $past(rst_n_i, 2) && $past(rst_n_i) |-> $stable(area0_width_o))
        else $error("area 0 width changed");
    cfg_width_a: assert property (
        go && ar >= AREA_2 && ar <= AREA_6 && mt != MEM_CARD
        |=> dec_o.width == $past(cw))
        else $error("area width mismatch");
    card_upper_a: assert property (
        go && ar == AREA_5 && mt == MEM_CARD && cw == WIDTH_16 && !sizing
        && req_i.byte_en[1] |=> !card_a_upper_enable_n_o)
        else $error("card upper enable missing");
    card_sizing_a: assert property (
        go && ar == AREA_5 && mt == MEM_CARD && sizing
        |=> dec_o.width == WIDTH_8)
        else $error("card sizing width mismatch");
endmodule
bind adbw_top adbw_chk adbw_chk_i (.ref_clk_i, .rst_n_i, .clk_en_i,
    .width_strap_high_i, .width_strap_low_i, .area_width_config_i,
    .area_mem_type_i, .little_endian_i, .card_io_space_i, .card_dyn_size_i,
    .card_iois16_n_i, .req_i, .area_select_n_o, .card_a_upper_enable_n_o,
    .dec_o, .area0_width_o, .io_access_o);

// ---- test/tb_adbw_top.sv ----
/* Testbench for adbw_top: straps, every area (all but area 2 via a shadow copy), card
   enables and dynamic sizing. Needs adbw_mem_model and adbw_chk. */
`timescale 1ns/1ps
module tb_adbw_top;
    import adbw_pkg::*;
    localparam logic [15:0] CFG = 16'h39A0;
    logic ref_clk_i, rst_n_i, clk_en_i, width_strap_high_i, width_strap_low_i;
    logic little_endian_i, card_io_space_i, card_dyn_size_i, card_iois16_n_i;
    logic port_function_i, card_a_upper_enable_n_o, card_b_upper_enable_n_o;
    logic config_error_o, io_access_o, hit;
    logic [CFG_W-1:0] area_width_config_i, area_mem_type_i;
    logic [NUM_SELECTS-1:0] area_select_n_o;
    logic [1:0] area0_width_o;
    logic [2:0] hit_area;
    adbw_req_t req_i;
    adbw_dec_t dec_o;
    int err_total, checked;
    adbw_top adbw_top_i (.ref_clk_i, .rst_n_i, .clk_en_i, .width_strap_high_i,
        .width_strap_low_i, .area_width_config_i, .area_mem_type_i,
        .little_endian_i, .card_io_space_i, .card_dyn_size_i, .card_iois16_n_i,
        .port_function_i, .req_i, .area_select_n_o, .card_a_upper_enable_n_o,
        .card_b_upper_enable_n_o, .dec_o, .area0_width_o, .config_error_o,
        .io_access_o);
    adbw_mem_model adbw_mem_model_i (.select_n_i(area_select_n_o),
        .hit_o(hit), .hit_area_o(hit_area));
    initial begin
        ref_clk_i = 1'h0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        err_total++;
        stop_test();
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Request stands one edge; outputs are read in the cycle after
    task automatic access(input logic [31:0] addr, input logic [3:0] be);
        @(posedge ref_clk_i);
        #1;
        req_i = '{1'h1, 1'h0, addr[31:29] != UNTRANSLATED_TOP, be, addr};
        @(posedge ref_clk_i);
        #1;
        req_i.valid = 1'h0;
    endtask
    function automatic logic [1:0] exp_w(input logic [2:0] a);
        if (a == AREA_0)
            return WIDTH_16;
        if (a == AREA_1 || a == AREA_7)
            return WIDTH_32;
        return CFG[2*a+:2];
    endfunction
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_strap();
        #1;
        rst_n_i = 1'h1;
        @(posedge ref_clk_i);
        #1;
        chk(8'(area0_width_o), 8'(WIDTH_16));
        {width_strap_high_i, width_strap_low_i} = 2'h1;
    endtask
    task automatic t_areas();
        logic [2:0] a;
        logic [6:0] es;
        logic [2:0] up;
        for (int i = 0; i < 8; i++) begin
            a = 3'(i);
            es = 7'h7F;
            if (a != AREA_1 && a != AREA_7)
                es[a] = 1'h0;
            up = (i == 1) ? UNTRANSLATED_TOP : 3'((i + 5) % 7);
            access({up, a, i[0] ? 26'h3FFFFFF : 26'h0}, 4'hF);
            chk(8'(dec_o.area), 8'(a));
            chk(8'(dec_o.width), 8'(exp_w(a)));
            chk(8'(area_select_n_o), 8'(es));
            chk(8'({hit, hit_area}), 8'(&es ? 4'h0 : {1'h1, a}));
            chk(8'({io_access_o, config_error_o}),
                8'({2{a == AREA_7}}));
            chk(8'({card_a_upper_enable_n_o,
                card_b_upper_enable_n_o}), 8'h03);
        end
        @(posedge ref_clk_i);
        #1;
        chk(8'(area_select_n_o), 8'h7F);
    endtask
    task automatic t_card();
        area_mem_type_i = 16'h2850;
        area_width_config_i[13:12] = WIDTH_16;
        access(32'h14000000, 4'h3);
        chk({area_select_n_o, card_a_upper_enable_n_o}, 8'hBE);
        chk(8'({card_b_upper_enable_n_o, dec_o.card}), 8'h03);
        access(32'hB8000000, 4'h8);
        chk({area_select_n_o, card_b_upper_enable_n_o}, 8'h7E);
        chk(8'(config_error_o), 8'h00);
        access(32'h14000000, 4'h1);
        chk({area_select_n_o, card_a_upper_enable_n_o}, 8'hBF);
    endtask
    task automatic t_dyn();
        card_io_space_i = 1'h1;
        card_dyn_size_i = 1'h1;
        for (int le = 1; le >= 0; le--) begin
            little_endian_i = le[0];
            access(32'h14000000, 4'h1);
            chk(8'(dec_o.width), le ? 8'(WIDTH_8) : 8'(WIDTH_16));
        end
    endtask
    task automatic t_cfg();
        area_width_config_i = CFG;
        area_mem_type_i = 16'h0050;
        port_function_i = 1'h1;
        access(32'h18000000, 4'hF);
        chk(8'(config_error_o), 8'h01);
        access(32'h10000000, 4'hF);
        chk(8'(config_error_o), 8'h00);
        port_function_i = 1'h0;
        area_width_config_i[7:6] = WIDTH_8;
        access(32'h0C000000, 4'hF);
        chk(8'({dec_o.width, config_error_o}), 8'h03);
        // Enable low: the area 3 select must stay frozen
        clk_en_i = 1'h0;
        access(32'h10000000, 4'hF);
        chk(8'(area_select_n_o), 8'h77);
        clk_en_i = 1'h1;
        @(posedge ref_clk_i);
        #1;
        chk(8'(area_select_n_o), 8'h7F);
    endtask
    initial begin
        {rst_n_i, width_strap_low_i, little_endian_i, card_io_space_i} = 4'h0;
        {clk_en_i, width_strap_high_i, card_iois16_n_i} = 3'h7;
        {card_dyn_size_i, port_function_i} = 2'h0;
        area_width_config_i = CFG;
        area_mem_type_i = 16'h0050;
        req_i = '0;
        repeat (16) @(posedge ref_clk_i);
        t_strap();
        t_areas();
        t_card();
        t_dyn();
        t_cfg();
        stop_test();
    end
endmodule
